//--- logic/switch_control_pkg.sv
package switch_control_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] SWITCH_CONTROL_OFFSET = 12'h404;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int HOT_RESET_TRIGGER_BIT = 1;
  localparam int RESET_HALT_BIT = 2;
  localparam int REGISTER_UNLOCK_BIT = 3;
  localparam int POWER_BUDGET_UNLOCK_BIT = 4;
  localparam int NO_LINKDOWN_HOT_RESET_BIT = 5;
  localparam int SKIP_EEPROM_ON_HOT_RESET_BIT = 6;
  localparam int RELAXED_ORDER_OFF_BIT = 7;
  localparam int PEER_ROUTING_OFF_BIT = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RESET_HALT_RST = 1'h0;
  localparam logic REGISTER_UNLOCK_RST = 1'h0;
  localparam logic POWER_BUDGET_UNLOCK_RST = 1'h0;
  localparam logic NO_LINKDOWN_HOT_RESET_RST = 1'h0;
  localparam logic SKIP_EEPROM_ON_HOT_RESET_RST = 1'h0;
  localparam logic RELAXED_ORDER_OFF_RST = 1'h0;
  localparam logic PEER_ROUTING_OFF_RST = 1'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TRIG_IDLE,
    TRIG_COMPLETE,
    TRIG_FIRE
  } trig_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } reg_cpl_t;

  typedef struct packed {
    logic reset_halt;
    logic register_unlock;
    logic power_budget_unlock;
    logic no_linkdown_hot_reset;
    logic skip_eeprom_on_hot_reset;
    logic relaxed_order_off;
    logic peer_routing_off;
  } ctl_t;

  typedef struct packed {
    ctl_t ctl;
    trig_state_t trig;
    reg_cpl_t cpl;
    logic dl_down_seen;
    logic hot_reset;
    logic link_retrain;
  } state_t;

endpackage : switch_control_pkg

//--- logic/switch_control_bits.sv
// Notes on behaviour
// - writing one to bit 1 starts hot reset plus upstream link retrain
// - hot reset trigger ignores zero writes and always reads zero
// - completion for the triggering write goes out before reset fires
// - reset halt bit holds all logic but the SMBus side in reset
// - reset halt loads from pin in reset or from EEPROM, else fixed
// - unlock bit set lets lock-protected fields update, else read-only
// - unlock resets to zero but is set during every reset operation
// - power budget unlock, itself lock-protected, opens budget registers
// - bit 5 suppresses hot reset from upstream link entering DL_Down
// - bit 6 skips the EEPROM load step of the hot reset sequence
// - bit 7 turns off relaxed ordering, forcing strict order
// - bit 8 makes non-upstream downstream traffic unsupported requests
// - sticky fields keep their values through a hot reset
`timescale 1ns/1ps
module switch_control_bits
(
  // clock and fundamental reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // register requests from config path or slave SMBus
  input wire switch_control_pkg::reg_req_t req_in,
  // reset operation status from the reset sequencer
  input wire logic reset_active_in,
  input wire logic eeprom_init_in,
  input wire logic reset_halt_pin_in,
  // hot reset causes from the upstream link
  input wire logic upstream_dl_down_in,
  input wire logic link_hot_reset_in,
  // register completion
  output switch_control_pkg::reg_cpl_t cpl_out,
  // hot reset requests to the reset sequencer
  output logic hot_reset_out,
  output logic link_retrain_out,
  // control levels to the rest of the switch
  output logic core_reset_halt_out,
  output logic lock_write_enable_out,
  output logic power_budget_write_enable_out,
  output logic skip_eeprom_on_hot_reset_out,
  output logic relaxed_order_off_out,
  output logic peer_routing_off_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hits_ctl(input switch_control_pkg::reg_req_t r);
    hits_ctl = r.valid && (r.addr == switch_control_pkg::SWITCH_CONTROL_OFFSET);
  endfunction : hits_ctl

  function automatic logic [31:0] pack_ctl(input switch_control_pkg::ctl_t c);
    logic [31:0] v;
    v = switch_control_pkg::READ_ZERO;
    v[switch_control_pkg::RESET_HALT_BIT] = c.reset_halt;
    v[switch_control_pkg::REGISTER_UNLOCK_BIT] = c.register_unlock;
    v[switch_control_pkg::POWER_BUDGET_UNLOCK_BIT] = c.power_budget_unlock;
    v[switch_control_pkg::NO_LINKDOWN_HOT_RESET_BIT] =
      c.no_linkdown_hot_reset;
    v[switch_control_pkg::SKIP_EEPROM_ON_HOT_RESET_BIT] =
      c.skip_eeprom_on_hot_reset;
    v[switch_control_pkg::RELAXED_ORDER_OFF_BIT] = c.relaxed_order_off;
    v[switch_control_pkg::PEER_ROUTING_OFF_BIT] = c.peer_routing_off;
    pack_ctl = v;
  endfunction : pack_ctl

  switch_control_pkg::state_t st;
  switch_control_pkg::state_t next_st;
  logic ctl_wr;
  logic trig_wr;
  logic dl_down_edge;
  logic no_ld_bit;

  // mask bit copy, read by the link-down check below
  assign no_ld_bit = st.ctl.no_linkdown_hot_reset;
  assign ctl_wr = hits_ctl(req_in) && req_in.write;
  // trigger only on a one, a zero write does nothing
  assign trig_wr = ctl_wr &&
    req_in.wdata[switch_control_pkg::HOT_RESET_TRIGGER_BIT];
  assign dl_down_edge = upstream_dl_down_in && !st.dl_down_seen;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // no hot reset input ever touches ctl: rst_n_in clears it, reset_active_in reloads halt and unlock
  always_comb
  begin
    next_st = st;
    next_st.cpl.valid = 1'b0;
    next_st.hot_reset = 1'b0;
    next_st.link_retrain = 1'b0;
    next_st.dl_down_seen = upstream_dl_down_in;
    // every request completes, unmapped reads return zero
    if (req_in.valid)
    begin
      next_st.cpl.valid = 1'b1;
      next_st.cpl.rdata = hits_ctl(req_in) ? pack_ctl(st.ctl)
                        : switch_control_pkg::READ_ZERO;
    end
    if (ctl_wr)
    begin
      // halt bit only writable while EEPROM init runs
      if (eeprom_init_in)
        next_st.ctl.reset_halt =
          req_in.wdata[switch_control_pkg::RESET_HALT_BIT];
      next_st.ctl.register_unlock =
        req_in.wdata[switch_control_pkg::REGISTER_UNLOCK_BIT];
      // lock-protected field, dropped silently when locked
      if (st.ctl.register_unlock)
        next_st.ctl.power_budget_unlock =
          req_in.wdata[switch_control_pkg::POWER_BUDGET_UNLOCK_BIT];
      next_st.ctl.no_linkdown_hot_reset =
        req_in.wdata[switch_control_pkg::NO_LINKDOWN_HOT_RESET_BIT];
      next_st.ctl.skip_eeprom_on_hot_reset =
        req_in.wdata[switch_control_pkg::SKIP_EEPROM_ON_HOT_RESET_BIT];
      next_st.ctl.relaxed_order_off =
        req_in.wdata[switch_control_pkg::RELAXED_ORDER_OFF_BIT];
      next_st.ctl.peer_routing_off =
        req_in.wdata[switch_control_pkg::PEER_ROUTING_OFF_BIT];
    end
    // reset operation wins over a write in the same cycle
    if (reset_active_in)
    begin
      next_st.ctl.reset_halt = reset_halt_pin_in;
      next_st.ctl.register_unlock = 1'b1;
    end
    // write trigger: completion first, then reset with retrain
    case (st.trig)
      switch_control_pkg::TRIG_IDLE:
        if (trig_wr)
          next_st.trig = switch_control_pkg::TRIG_COMPLETE;
      switch_control_pkg::TRIG_COMPLETE:
        next_st.trig = switch_control_pkg::TRIG_FIRE;
      switch_control_pkg::TRIG_FIRE:
      begin
        next_st.trig = switch_control_pkg::TRIG_IDLE;
        next_st.hot_reset = 1'b1;
        next_st.link_retrain = 1'b1;
      end
      default:
        next_st.trig = switch_control_pkg::TRIG_IDLE;
    endcase
    // link causes; only the DL_Down one can be masked
    if (link_hot_reset_in)
      next_st.hot_reset = 1'b1;
    if (dl_down_edge && !st.ctl.no_linkdown_hot_reset)
      next_st.hot_reset = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st.ctl.reset_halt <= switch_control_pkg::RESET_HALT_RST;
      st.ctl.register_unlock <= switch_control_pkg::REGISTER_UNLOCK_RST;
      st.ctl.power_budget_unlock <=
        switch_control_pkg::POWER_BUDGET_UNLOCK_RST;
      st.ctl.no_linkdown_hot_reset <=
        switch_control_pkg::NO_LINKDOWN_HOT_RESET_RST;
      st.ctl.skip_eeprom_on_hot_reset <=
        switch_control_pkg::SKIP_EEPROM_ON_HOT_RESET_RST;
      st.ctl.relaxed_order_off <= switch_control_pkg::RELAXED_ORDER_OFF_RST;
      st.ctl.peer_routing_off <= switch_control_pkg::PEER_ROUTING_OFF_RST;
      st.trig <= switch_control_pkg::TRIG_IDLE;
      st.cpl <= '0;
      st.dl_down_seen <= 1'b0;
      st.hot_reset <= 1'b0;
      st.link_retrain <= 1'b0;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign cpl_out = st.cpl;
  assign hot_reset_out = st.hot_reset;
  assign link_retrain_out = st.link_retrain;
  assign core_reset_halt_out = st.ctl.reset_halt;
  assign lock_write_enable_out = st.ctl.register_unlock;
  assign power_budget_write_enable_out =
    st.ctl.power_budget_unlock;
  assign skip_eeprom_on_hot_reset_out =
    st.ctl.skip_eeprom_on_hot_reset;
  assign relaxed_order_off_out = st.ctl.relaxed_order_off;
  assign peer_routing_off_out = st.ctl.peer_routing_off;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence trig_write_s;
    trig_wr && st.trig == switch_control_pkg::TRIG_IDLE;
  endsequence
  sequence cpl_then_fire_s;
    cpl_out.valid ##2 (hot_reset_out && link_retrain_out);
  endsequence

  trigger_fires_a: assert property (trig_write_s |=> cpl_then_fire_s)
    else $error("trigger write did not complete then fire");
  trigger_reads_zero_a: assert property (cpl_out.valid |->
    !cpl_out.rdata[switch_control_pkg::HOT_RESET_TRIGGER_BIT])
    else $error("trigger bit read back as one");
  // a later request may complete alongside the pulse, so only the
  // completion two cycles back is required
  cpl_before_reset_a: assert property (link_retrain_out |->
    $past(cpl_out.valid, 2))
    else $error("retrain not preceded by completion");
  halt_follows_pin_a: assert property (reset_active_in |=>
    core_reset_halt_out == $past(reset_halt_pin_in))
    else $error("halt bit not loaded from pin");
  halt_locked_out_a: assert property (!reset_active_in && !eeprom_init_in
    |=> $stable(core_reset_halt_out))
    else $error("halt bit changed outside reset or EEPROM load");
  unlock_in_reset_a: assert property (reset_active_in |=>
    lock_write_enable_out)
    else $error("unlock not set by reset operation");
  locked_write_drop_a: assert property (ctl_wr && !lock_write_enable_out
    |=> $stable(power_budget_write_enable_out) && cpl_out.valid)
    else $error("locked field changed or write not completed");
  unlocked_write_a: assert property (ctl_wr && lock_write_enable_out |=>
    power_budget_write_enable_out == $past(req_in.wdata[
      switch_control_pkg::POWER_BUDGET_UNLOCK_BIT]))
    else $error("unlocked field did not take write");
  linkdown_masked_a: assert property (dl_down_edge && no_ld_bit &&
    !link_hot_reset_in && st.trig != switch_control_pkg::TRIG_FIRE
    |=> !hot_reset_out)
    else $error("masked link down caused hot reset");
  sticky_keep_a: assert property (hot_reset_out && !ctl_wr &&
    !reset_active_in |=> $stable(relaxed_order_off_out) &&
    $stable(peer_routing_off_out))
    else $error("sticky field changed by hot reset");

endmodule : switch_control_bits

//--- verification/config_requester.sv
`timescale 1ns/1ps
module config_requester
(
  // clock
  input wire logic clk_in,
  // completion from the block
  input wire switch_control_pkg::reg_cpl_t cpl_in,
  // requests to the block
  output switch_control_pkg::reg_req_t req_out
);
  initial req_out = '0;

  // request held until its completion shows; released fields show
  // inverted values so a stale sample never looks right by accident
  task automatic access(input logic wr, input logic [11:0] addr,
    input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    @(negedge clk_in);
    req_out <= '{1'b1, wr, addr, wd};
    // completion stands one cycle after the taking edge, so it is
    // looked at on the falling edge inside that cycle
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(negedge clk_in);
      ok = (cpl_in.valid === 1'b1);
    end
    req_out <= '{1'b0, ~wr, ~addr, ~wd};
    rd = cpl_in.rdata;
  endtask : access
endmodule : config_requester

//--- verification/tb_switch_control_bits.sv
`timescale 1ns/1ps
module tb_switch_control_bits;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reset_active_in = 1'b0;
  logic pin = 1'b0;
  logic dl_down = 1'b0;
  logic link_hot = 1'b0;
  logic ee = 1'b0;
  switch_control_pkg::reg_req_t req;
  switch_control_pkg::reg_cpl_t cpl;
  logic hot, retrain, halt, lock_we, pb_we, skip_ee, ro_off, p2p_off;
  int err_total = 0;
  int checked = 0;
  int hot_n = 0;
  int retrain_n = 0;
  int h0;
  int r0;
  logic [31:0] rd;
  logic ok;

  always #10 clk_in = ~clk_in;

  // pulse counters, so missing and doubled pulses both show
  always @(posedge clk_in)
  begin
    if (hot === 1'b1) hot_n++;
    if (retrain === 1'b1) retrain_n++;
  end

  switch_control_bits i_switch_control_bits (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .req_in(req), .reset_active_in(reset_active_in),
    .eeprom_init_in(ee), .reset_halt_pin_in(pin),
    .upstream_dl_down_in(dl_down), .link_hot_reset_in(link_hot),
    .cpl_out(cpl), .hot_reset_out(hot), .link_retrain_out(retrain),
    .core_reset_halt_out(halt), .lock_write_enable_out(lock_we),
    .power_budget_write_enable_out(pb_we),
    .skip_eeprom_on_hot_reset_out(skip_ee),
    .relaxed_order_off_out(ro_off), .peer_routing_off_out(p2p_off));

  config_requester i_config_requester (.clk_in(clk_in), .cpl_in(cpl),
    .req_out(req));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a missing completion is a mismatch and ends the run
  task automatic acc(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    i_config_requester.access(wr, a, wd, rd, ok);
    if (!ok)
    begin
      err_total++;
      finish_test();
    end
  endtask : acc

  task automatic reset_op(input logic p);
    @(negedge clk_in);
    pin = p;
    reset_active_in = 1'b1;
    repeat (3) @(negedge clk_in);
    reset_active_in = 1'b0;
  endtask : reset_op

  function automatic logic [31:0] lv();
    return {26'h0, halt, lock_we, pb_we, skip_ee, ro_off, p2p_off};
  endfunction : lv

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic halt_load();
    reset_op(1'b1);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_000C);
    check(lv(), 32'h0000_0030);
  endtask : halt_load

  // set-up writes during halt, as an SMBus master would
  task automatic halted_setup();
    acc(1'b1, 12'h404, 32'h0000_01F0);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01F4);
    check(lv(), 32'h0000_002F);
    acc(1'b1, 12'h400, 32'hFFFF_FFFF);
    acc(1'b0, 12'h400, 32'h0);
    check(rd, 32'h0000_0000);
  endtask : halted_setup

  task automatic locked_write();
    acc(1'b1, 12'h404, 32'h0000_0000);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_0014);
    check(lv(), 32'h0000_0028);
  endtask : locked_write

  task automatic sticky_keep();
    acc(1'b1, 12'h404, 32'h0000_01E8);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01FC);
    reset_op(1'b0);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01F8);
  endtask : sticky_keep

  task automatic trigger();
    h0 = hot_n;
    acc(1'b1, 12'h404, 32'h0000_01FA);
    check({31'h0, hot}, 32'h0);
    @(posedge clk_in);
    #1;
    check({31'h0, hot}, 32'h0);
    @(posedge clk_in);
    #1;
    check({30'h0, hot, retrain}, 32'h3);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01F8);
    acc(1'b1, 12'h404, 32'h0000_01F8);
    repeat (4) @(negedge clk_in);
    check(32'(hot_n - h0), 32'h1);
  endtask : trigger

  task automatic link_down();
    h0 = hot_n;
    r0 = retrain_n;
    dl_down = 1'b1;
    repeat (4) @(negedge clk_in);
    check(32'(hot_n - h0), 32'h0);
    link_hot = 1'b1;
    @(negedge clk_in);
    link_hot = 1'b0;
    repeat (3) @(negedge clk_in);
    check(32'(hot_n - h0), 32'h1);
    acc(1'b1, 12'h404, 32'h0000_01D8);
    dl_down = 1'b0;
    @(negedge clk_in);
    dl_down = 1'b1;
    repeat (4) @(negedge clk_in);
    check(32'(hot_n - h0), 32'h2);
    check(32'(retrain_n - r0), 32'h0);
  endtask : link_down

  // EEPROM init may rewrite the halt bit, a plain write may not
  task automatic eeprom_load();
    ee = 1'b1;
    acc(1'b1, 12'h404, 32'h0000_01DC);
    ee = 1'b0;
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01DC);
    acc(1'b1, 12'h404, 32'h0000_01D8);
    acc(1'b0, 12'h404, 32'h0);
    check(rd, 32'h0000_01DC);
  endtask : eeprom_load

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge clk_in);
    rst_n_in = 1'b1;
    halt_load();
    halted_setup();
    locked_write();
    sticky_keep();
    trigger();
    link_down();
    eeprom_load();
    finish_test();
  end
endmodule : tb_switch_control_bits
